// ===== logic/sloc_lane_cfg.sv
// sloc_lane_cfg: serial lane output configuration bank with its lane
// crossbar, polarity and power-down datapath.
// assumes a classic wishbone master on CLOCK and logical lane bits from
// logic on the same clock.
`timescale 1ns/1ps
module sloc_lane_cfg
    import sloc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [15:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic WB_ACK_O,
    output logic [31:0] WB_DAT_O,
    input wire logic [3:0] LOGICAL_LANE_DATA,
    output logic [3:0] SERIAL_LANE_OUTPUT,
    output logic [3:0] LANE_POWER_DOWN,
    output logic [11:0] LANE_SWING_CODE
);

    // bus request bundle and write path
    sloc_wb_req_type wb_req;
    wire logic wr_stb;
    wire logic [7:0] wr_byte;
    logic [7:0] rd_value;

    // stored configuration
    logic [3:0] power_down_reg;
    logic [3:0] power_down_next;
    logic [7:0] data_invert_reg;
    logic [7:0] data_invert_next;
    logic [3:0][2:0] assign_reg;
    logic [3:0][2:0] assign_next;
    logic [3:0][2:0] swing_reg;
    logic [3:0][2:0] swing_next;

    // decode hits
    wire logic hit_power_down;
    wire logic hit_data_invert;
    wire logic [3:0] hit_assign;
    wire logic [3:0] hit_swing;
    wire logic hit_any;

    // per-lane views of the shared registers
    wire logic [3:0] lane_invert;
    sloc_lane_cfg_type [3:0] lane_cfg;
    wire logic [3:0] lane_bits;

    // read values of the power-down, assignment and swing registers with reserved bits forced low
    wire logic [7:0] rd_power_down;
    wire logic [3:0][7:0] rd_assign;
    wire logic [3:0][7:0] rd_swing;
    logic [7:0] rd_assign_any;
    logic [7:0] rd_swing_any;

    // gather bus pins; the two low address bits pick a byte inside the word
    // and play no part in the decode
    assign wb_req.cyc = WB_CYC_I;
    assign wb_req.stb = WB_STB_I;
    assign wb_req.we = WB_WE_I;
    assign wb_req.idx = WB_ADR_I[15:2];
    assign wb_req.sel = WB_SEL_I;
    assign wb_req.dat = WB_DAT_I;
    assign wr_byte = WB_DAT_I[7:0];

    // register decode on the word index
    assign hit_power_down = (wb_req.idx == SLOC_IDX_POWER_DOWN);
    assign hit_data_invert = (wb_req.idx == SLOC_IDX_DATA_INVERT);
    assign hit_any = hit_power_down | hit_data_invert
                   | (|hit_assign) | (|hit_swing);

    // per-lane decode, field views and read values
    genvar n;
    generate
        for (n = 0; n < SLOC_LANES; n = n + 1) begin : g_lane
            assign hit_assign[n] = (wb_req.idx == SLOC_IDX_ASSIGN[n]);
            assign hit_swing[n] = (wb_req.idx == SLOC_IDX_SWING[n]);
            // each lane reads its own bit of the shared registers
            assign lane_invert[n] = data_invert_reg[n * SLOC_INV_STRIDE];
            // even bit per lane, odd bits stay zero
            assign rd_power_down[n * SLOC_PD_STRIDE] = power_down_reg[n];
            assign rd_power_down[n * SLOC_PD_STRIDE + 1] = 1'b0;
            // upper five bits of the assignment word read zero
            assign rd_assign[n] = {5'h00, assign_reg[n]};
            assign rd_swing[n] = {5'h00, swing_reg[n]};
            // bundle the lane settings for its crossbar slice
            assign lane_cfg[n].power_down = power_down_reg[n];
            assign lane_cfg[n].invert = lane_invert[n];
            assign lane_cfg[n].assign_code = assign_reg[n];
        end
    endgenerate

    // pick the one assignment or swing word that was hit; hits are exclusive
    always_comb begin
        rd_assign_any = 8'h00;
        rd_swing_any = 8'h00;
        for (int i = 0; i < SLOC_LANES; i++) begin
            if (hit_assign[i]) begin
                rd_assign_any = rd_assign[i];
            end
            if (hit_swing[i]) begin
                rd_swing_any = rd_swing[i];
            end
        end
    end

    // read multiplexer; unmapped words answer with zero
    always_comb begin
        if (hit_power_down) begin
            rd_value = rd_power_down;
        end else if (hit_data_invert) begin
            rd_value = data_invert_reg;
        end else if (|hit_assign) begin
            rd_value = rd_assign_any;
        end else if (hit_any) begin
            rd_value = rd_swing_any; // only a swing word is left
        end else begin
            rd_value = 8'h00;
        end
    end

    // next value of the power-down bits, taken from the even bits of the
    // written byte; odd bits of the byte are dropped
    always_comb begin
        power_down_next = power_down_reg;
        if (wr_stb && hit_power_down) begin
            for (int i = 0; i < SLOC_LANES; i++) begin
                power_down_next[i] = wr_byte[i * SLOC_PD_STRIDE];
            end
        end
    end

    // the invert word keeps all eight bits, reserved ones included, since
    // they read back what was written
    always_comb begin
        data_invert_next = data_invert_reg;
        if (wr_stb && hit_data_invert) begin
            data_invert_next = wr_byte;
        end
    end

    // assignment and swing fields take the low three bits of the write;
    // swing codes above two are stored as written, the analog side treats
    // them as undefined so software must keep away from them
    always_comb begin
        assign_next = assign_reg;
        swing_next = swing_reg;
        for (int i = 0; i < SLOC_LANES; i++) begin
            if (wr_stb && hit_assign[i]) begin
                assign_next[i] = wr_byte[SLOC_SEL_LSB +: SLOC_SEL_W];
            end
            if (wr_stb && hit_swing[i]) begin
                swing_next[i] = wr_byte[SLOC_SWING_LSB +: SLOC_SWING_W];
            end
        end
    end

    // power-down and invert registers; all lanes powered after reset
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            // lane bits sit on the even positions of the reset byte
            power_down_reg <= {SLOC_POWER_DOWN_RST[6], SLOC_POWER_DOWN_RST[4],
                SLOC_POWER_DOWN_RST[2], SLOC_POWER_DOWN_RST[0]};
            data_invert_reg <= SLOC_DATA_INVERT_RST;
        end else begin
            power_down_reg <= power_down_next;
            data_invert_reg <= data_invert_next;
        end
    end

    // assignment registers come up as the 0, 0, 2, 3 map
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            assign_reg <= SLOC_ASSIGN_RST;
        end else begin
            assign_reg <= assign_next;
        end
    end

    // swing registers start on the reduced level to keep edge rates down
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < SLOC_LANES; i++) begin
                swing_reg[i] <= SLOC_SWING_RST;
            end
        end else begin
            swing_reg <= swing_next;
        end
    end

    // the config ports are the register flops themselves
    assign LANE_POWER_DOWN = power_down_reg;
    assign LANE_SWING_CODE = swing_reg;

    // bus front end: ack one cycle after the request, write on the ack edge
    sloc_wb_slave u_wb (
        .clk(CLOCK),
        .rst(RST),
        .req(wb_req),
        .rd_value(rd_value),
        .wr_stb(wr_stb),
        .ack(WB_ACK_O),
        .dat_out(WB_DAT_O)
    );

    // one crossbar slice per physical lane
    generate
        for (n = 0; n < SLOC_LANES; n = n + 1) begin : g_xbar
            sloc_lane_xbar u_xbar (
                .clk(CLOCK),
                .rst(RST),
                .cfg(lane_cfg[n]),
                .logical_bits(LOGICAL_LANE_DATA),
                .phys_bit(lane_bits[n])
            );
        end
    endgenerate

    assign SERIAL_LANE_OUTPUT = lane_bits;

    // unmapped words are still acknowledged so a stray access cannot hang
    // the bus; they read zero through the last branch of the read mux

endmodule : sloc_lane_cfg

// ===== logic/sloc_lane_xbar.sv
// sloc_lane_xbar: one physical lane of the output crossbar.
// assumes logical lane bits arrive on the same clock, one bit per cycle.
`timescale 1ns/1ps
module sloc_lane_xbar
    import sloc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire sloc_lane_cfg_type cfg,
    input wire logic [3:0] logical_bits,
    output logic phys_bit
);
    logic out_reg;
    wire logic picked;
    wire logic code_ok;
    wire logic out_next;

    // codes 4..7 pick no logical lane, the lane then sends its invert bit
    assign code_ok = (cfg.assign_code[2] == 1'b0);
    assign picked = code_ok & logical_bits[cfg.assign_code[1:0]];
    // a forced-off lane sends a steady low instead of inverted idle
    assign out_next = cfg.power_down ? 1'b0 : (picked ^ cfg.invert);

    // registered so the lane output comes from a flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
        end
    end

    assign phys_bit = out_reg;

endmodule : sloc_lane_xbar

// ===== logic/sloc_pkg.sv
// sloc_pkg: constants and carrier types for the serial lane output
// configuration bank.
// assumes a 32-bit classic wishbone bus where each 8-bit register takes one
// aligned word, so the byte address is four times the register index.
package sloc_pkg;

    // lane count and field widths
    localparam int SLOC_LANES = 4;
    localparam int SLOC_REG_W = 8;
    localparam int SLOC_SEL_W = 3;
    localparam int SLOC_SWING_W = 3;
    localparam int SLOC_IDX_W = 14;

    // register indices; the byte address is the index shifted left by two
    localparam logic [13:0] SLOC_IDX_POWER_DOWN = 14'h05b0;
    localparam logic [13:0] SLOC_IDX_LANE0_ASSIGN = 14'h05b2;
    localparam logic [13:0] SLOC_IDX_LANE1_ASSIGN = 14'h05b3;
    localparam logic [13:0] SLOC_IDX_LANE2_ASSIGN = 14'h05b5;
    localparam logic [13:0] SLOC_IDX_LANE3_ASSIGN = 14'h05b6;
    localparam logic [13:0] SLOC_IDX_DATA_INVERT = 14'h05bf;
    localparam logic [13:0] SLOC_IDX_LANE0_SWING = 14'h05c0;
    localparam logic [13:0] SLOC_IDX_LANE1_SWING = 14'h05c1;
    localparam logic [13:0] SLOC_IDX_LANE2_SWING = 14'h05c2;
    localparam logic [13:0] SLOC_IDX_LANE3_SWING = 14'h05c3;

    // per-lane index tables, entry n belongs to physical lane n
    localparam logic [3:0][13:0] SLOC_IDX_ASSIGN = {
        SLOC_IDX_LANE3_ASSIGN, SLOC_IDX_LANE2_ASSIGN,
        SLOC_IDX_LANE1_ASSIGN, SLOC_IDX_LANE0_ASSIGN};
    localparam logic [3:0][13:0] SLOC_IDX_SWING = {
        SLOC_IDX_LANE3_SWING, SLOC_IDX_LANE2_SWING,
        SLOC_IDX_LANE1_SWING, SLOC_IDX_LANE0_SWING};

    // field positions: lane n sits at bit n*stride of the shared registers
    localparam int SLOC_PD_STRIDE = 2;
    localparam int SLOC_INV_STRIDE = 2;
    localparam int SLOC_SEL_LSB = 0;
    localparam int SLOC_SWING_LSB = 0;

    // reset values
    localparam logic [7:0] SLOC_POWER_DOWN_RST = 8'h00;
    localparam logic [7:0] SLOC_DATA_INVERT_RST = 8'h00;
    localparam logic [3:0][2:0] SLOC_ASSIGN_RST = {3'h3, 3'h2, 3'h0, 3'h0};
    localparam logic [2:0] SLOC_SWING_RST = 3'h1;

    // swing level codes; codes above the last are undefined
    typedef enum logic [2:0] {
        SLOC_SWING_FULL = 3'h0,
        SLOC_SWING_0P850 = 3'h1,
        SLOC_SWING_0P750 = 3'h2
    } sloc_swing_type;

    // one bus request as seen by the slave
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [13:0] idx;
        logic [3:0] sel;
        logic [31:0] dat;
    } sloc_wb_req_type;

    // settings that steer one physical lane
    typedef struct packed {
        logic power_down;
        logic invert;
        logic [2:0] assign_code;
    } sloc_lane_cfg_type;

endpackage : sloc_pkg

// ===== logic/sloc_wb_slave.sv
// sloc_wb_slave: classic wishbone slave front end for the register bank.
// assumes a master that holds its request until it samples ack; the owner
// supplies combinational read data for the addressed register.
`timescale 1ns/1ps
module sloc_wb_slave
    import sloc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire sloc_wb_req_type req,
    input wire logic [7:0] rd_value,
    output logic wr_stb,
    output logic ack,
    output logic [31:0] dat_out
);
    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    wire logic req_live;

    // a request is live while cyc and stb are both high
    assign req_live = req.cyc & req.stb;
    // ack rises one cycle after the request and drops right after
    assign ack_next = req_live & ~ack_reg;
    // narrow data in the low byte, upper bits read as zero
    assign dat_next = ack_next ? {24'h000000, rd_value} : 32'h00000000;
    // write lands on the edge where the master sees ack, only lane 0 bytes
    assign wr_stb = req_live & req.we & ack_reg & req.sel[0];
    assign ack = ack_reg;
    assign dat_out = dat_reg;

    // answer registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

endmodule : sloc_wb_slave

// ===== tb/sloc_lane_cfg_properties.sv
// checker: bus and lane-output properties of the lane config bank
// assumes it is bound into sloc_lane_cfg and sees only its ports
`timescale 1ns/1ps
module sloc_cfg_chk
    import sloc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [15:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic WB_ACK_O,
    input wire logic [31:0] WB_DAT_O,
    input wire logic [3:0] SERIAL_LANE_OUTPUT,
    input wire logic [3:0] LANE_POWER_DOWN,
    input wire logic [11:0] LANE_SWING_CODE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    // lane bits of a power-down write, packed at stride two
    wire [3:0] pd_map = {WB_DAT_I[6], WB_DAT_I[4], WB_DAT_I[2], WB_DAT_I[0]};
    // a write taken at one edge and acked at the next
    sequence s_wr(logic [13:0] idx);
        WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0]
            && WB_ADR_I[15:2] == idx ##1 WB_ACK_O;
    endsequence
    a_ack_answer: assert property (
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
    a_ack_pulse: assert property (
        WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
    a_dat_idle: assert property (
        !WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("read data while idle");
    a_dat_upper: assert property (
        WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0) else $error("upper data set");
    a_pd_write: assert property (s_wr(SLOC_IDX_POWER_DOWN) |=>
        LANE_POWER_DOWN == $past(pd_map)) else $error("power-down wrong");
    a_swing_write: assert property (s_wr(SLOC_IDX_LANE3_SWING) |=>
        LANE_SWING_CODE[11:9] == $past(WB_DAT_I[2:0])) else $error("swing");
    a_reset_vals: assert property ($past(RST) |->
        LANE_SWING_CODE == 12'h249 && LANE_POWER_DOWN == 4'h0)
        else $error("reset values wrong");
    a_pd_forces: assert property (1'b1 |=>
        (SERIAL_LANE_OUTPUT & $past(LANE_POWER_DOWN)) == 4'h0)
        else $error("powered-down lane toggles");
    a_cfg_hold: assert property (!WB_ACK_O |=>
        $stable(LANE_SWING_CODE) && $stable(LANE_POWER_DOWN))
        else $error("config moved without a write");
endmodule : sloc_cfg_chk

bind sloc_lane_cfg sloc_cfg_chk chk_u (.CLOCK(CLOCK), .RST(RST),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O),
    .SERIAL_LANE_OUTPUT(SERIAL_LANE_OUTPUT),
    .LANE_POWER_DOWN(LANE_POWER_DOWN), .LANE_SWING_CODE(LANE_SWING_CODE));

// ===== tb/sloc_lane_cfg_tb.sv
// testbench: register access over wishbone, then random lane traffic
// assumes the bank, its checker and the receiver model are compiled first
`timescale 1ns/1ps
module sloc_lane_cfg_tb
    import sloc_pkg::*;
;
    logic CLOCK = 1'b0, RST = 1'b1, WB_CYC_I = 1'b0, WB_STB_I = 1'b0;
    logic WB_WE_I = 1'b0, mark = 1'b0, WB_ACK_O, rx_mark;
    logic [15:0] WB_ADR_I = 16'h0;
    logic [3:0] WB_SEL_I = 4'h0, LOGICAL_LANE_DATA = 4'h0, rx_bits;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O;
    logic [3:0] SERIAL_LANE_OUTPUT, LANE_POWER_DOWN, pd_s, inv_s;
    logic [11:0] LANE_SWING_CODE;
    logic [3:0][2:0] asg_s;
    logic [7:0] rd_q[$];
    logic [3:0] lane_q[$];
    int fail_count = 0, num_checks = 0;
    // register table: index, value after reset, value after writing ones
    logic [13:0] idx_t[10] = '{14'h05b0, 14'h05b2, 14'h05b3, 14'h05b5,
        14'h05b6, 14'h05bf, 14'h05c0, 14'h05c1, 14'h05c2, 14'h05c3};
    logic [7:0] rst_t[10] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h03, 8'h00,
        8'h01, 8'h01, 8'h01, 8'h01};
    logic [7:0] one_t[10] = '{8'h55, 8'h07, 8'h07, 8'h07, 8'h07, 8'hff,
        8'h07, 8'h07, 8'h07, 8'h07};

    always #5 CLOCK = ~CLOCK;

    sloc_lane_cfg dut_u (.CLOCK(CLOCK), .RST(RST), .WB_CYC_I(WB_CYC_I),
        .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
        .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
        .WB_DAT_O(WB_DAT_O), .LOGICAL_LANE_DATA(LOGICAL_LANE_DATA),
        .SERIAL_LANE_OUTPUT(SERIAL_LANE_OUTPUT),
        .LANE_POWER_DOWN(LANE_POWER_DOWN), .LANE_SWING_CODE(LANE_SWING_CODE));
    sloc_rx_model rx_u (.clk(CLOCK), .rst(RST), .lane_in(SERIAL_LANE_OUTPUT),
        .mark(mark), .rx_bits(rx_bits), .rx_mark(rx_mark));

    task automatic check(input string what, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [13:0] idx, logic [7:0] d);
        int n;
        n = 0;
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= {idx, 2'b00};
        WB_SEL_I <= 4'h1;
        WB_DAT_I <= {24'h0, d};
        do begin
            @(posedge CLOCK);
            n++;
        end while (WB_ACK_O !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            summarize();
        end
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        @(posedge CLOCK);
    endtask : wb

    task automatic rd(input logic [13:0] idx, input logic [7:0] e);
        rd_q.push_back(e);
        wb(1'b0, idx, 8'h00);
    endtask : rd

    // expected lanes from the bench's own copy of the settings
    function automatic logic [3:0] lane_exp(input logic [3:0] d);
        logic [3:0] e;
        for (int n = 0; n < 4; n++) begin
            // codes four to seven pick no logical lane, only invert remains
            e[n] = pd_s[n] ? 1'b0
                : (d[asg_s[n][1:0]] & ~asg_s[n][2]) ^ inv_s[n];
        end
        return e;
    endfunction : lane_exp

    // eight random logical words, each noted for the monitor
    task automatic stream();
        logic [3:0] d;
        repeat (8) begin
            d = 4'($urandom);
            LOGICAL_LANE_DATA <= d;
            mark <= 1'b1;
            lane_q.push_back(lane_exp(d));
            @(posedge CLOCK);
        end
        mark <= 1'b0;
        repeat (3) @(posedge CLOCK);
    endtask : stream

    // monitor: oldest note is taken when a read answer or lane word shows
    always @(posedge CLOCK) begin
        if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0 && rd_q.size() > 0) begin
            check("read", WB_DAT_O[7:0], rd_q.pop_front());
        end
        if (rx_mark === 1'b1 && lane_q.size() > 0) begin
            check("lane", {4'h0, rx_bits}, {4'h0, lane_q.pop_front()});
        end
    end

    initial begin
        logic [7:0] v;
        void'($urandom(20661));
        pd_s = 4'h0;
        inv_s = 4'h0;
        asg_s = SLOC_ASSIGN_RST;
        repeat (4) @(posedge CLOCK);
        RST <= 1'b0;
        @(posedge CLOCK);
        for (int i = 0; i < 10; i++) rd(idx_t[i], rst_t[i]);
        stream();
        // all ones shows which bits are reserved
        for (int i = 0; i < 10; i++) wb(1'b1, idx_t[i], 8'hff);
        for (int i = 0; i < 10; i++) rd(idx_t[i], one_t[i]);
        wb(1'b1, 14'h05b1, 8'hff);
        rd(14'h05b1, 8'h00);
        // random settings, each followed by live traffic
        repeat (6) begin
            v = 8'($urandom);
            wb(1'b1, SLOC_IDX_POWER_DOWN, v);
            pd_s = {v[6], v[4], v[2], v[0]};
            check("power", {4'h0, LANE_POWER_DOWN}, {4'h0, pd_s});
            v = 8'($urandom);
            wb(1'b1, SLOC_IDX_DATA_INVERT, v);
            inv_s = {v[6], v[4], v[2], v[0]};
            for (int n = 0; n < 4; n++) begin
                v = 8'($urandom % 4);
                wb(1'b1, SLOC_IDX_ASSIGN[n], v);
                asg_s[n] = v[2:0];
                v = 8'($urandom % 3);
                wb(1'b1, SLOC_IDX_SWING[n], v);
                rd(SLOC_IDX_SWING[n], v);
                check("swing", {5'h00, LANE_SWING_CODE[n * 3 +: 3]}, v);
            end
            stream();
        end
        // codes above three on a powered lane leave only the invert bit
        wb(1'b1, SLOC_IDX_POWER_DOWN, 8'h00);
        pd_s = 4'h0;
        v = 8'(4 + $urandom % 4);
        wb(1'b1, SLOC_IDX_LANE0_ASSIGN, v);
        asg_s[0] = v[2:0];
        stream();
        // a second reset mid-run must bring every default back
        RST <= 1'b1;
        repeat (2) @(posedge CLOCK);
        RST <= 1'b0;
        pd_s = 4'h0;
        inv_s = 4'h0;
        asg_s = SLOC_ASSIGN_RST;
        @(posedge CLOCK);
        for (int i = 0; i < 10; i++) rd(idx_t[i], rst_t[i]);
        check("swing", {4'h0, LANE_SWING_CODE[3:0]}, 8'h09);
        stream();
        repeat (4) @(posedge CLOCK);
        check("queues", 8'(rd_q.size() + lane_q.size()), 8'h00);
        summarize();
    end
endmodule : sloc_lane_cfg_tb

// ===== tb/sloc_rx_model.sv
// receiver model: captures the physical lanes each cycle
// assumes lanes and marks arrive on the bank's clock
`timescale 1ns/1ps
module sloc_rx_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] lane_in,
    input wire logic mark,
    output logic [3:0] rx_bits,
    output logic rx_mark
);
    logic mark_d;
    // mark delayed twice to line up with the bank's output register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mark_d <= 1'b0;
            rx_mark <= 1'b0;
            rx_bits <= 4'h0;
        end else begin
            mark_d <= mark;
            rx_mark <= mark_d;
            rx_bits <= lane_in;
        end
    end
endmodule : sloc_rx_model
